/* rdc_pkg.sv */
`default_nettype none
package rdc_pkg;
    // ==========================================================
    // Target address layout
    localparam logic [1:0] ADDR_TOP_BITS    = 2'h3;
    localparam logic [1:0] ADDR_MID_BITS    = 2'h0;
    localparam logic       DIR_READ         = 1'h1;

    // ==========================================================
    // Byte positions
    localparam logic [3:0] OFS_LEVEL_STATUS = 4'h0;
    localparam logic [3:0] OFS_RSVD_ONE     = 4'h1;
    localparam logic [3:0] OFS_LOOP_DEEMPH  = 4'h2;
    localparam logic [3:0] OFS_RX_DISABLE   = 4'h3;
    localparam logic [3:0] OFS_TX_DISABLE   = 4'h4;
    localparam logic [3:0] OFS_LAST         = 4'hB;
    localparam logic [3:0] OFS_SATURATE     = 4'hF;

    // ==========================================================
    // Field positions and reset values
    localparam int         LOOP_FIELD_HI    = 7;
    localparam int         LOOP_FIELD_LO    = 4;
    localparam int         DEEMPH_FIELD_HI  = 3;
    localparam int         DEEMPH_FIELD_LO  = 2;
    localparam logic [1:0] RSVD_LBDE_VALUE  = 2'h0;
    localparam logic [7:0] RSVD_BYTE_VALUE  = 8'h00;
    localparam logic [7:0] UNMAPPED_VALUE   = 8'h00;
    localparam logic [7:0] RX_OFF_RESET     = 8'h00;
    localparam logic [7:0] TX_OFF_RESET     = 8'h00;

    // ==========================================================
    // Timing
    localparam logic [1:0] STRAP_SETTLE     = 2'h3;
    localparam int         SYNC_WIDTH       = 17;

    // ==========================================================
    // Types
    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_ADDR     = 7'h02,
        ST_ACK_ADDR = 7'h04,
        ST_WDATA    = 7'h08,
        ST_ACK_W    = 7'h10,
        ST_RDATA    = 7'h20,
        ST_ACK_R    = 7'h40
    } rdc_state_t;

    typedef struct packed {
        logic loop_strap_n;
        logic deemph_strap_grp_a;
        logic deemph_strap_grp_b;
        logic addr_strap_bit_four;
        logic addr_strap_bit_one;
        logic addr_strap_bit_zero;
    } rdc_strap_t;

    typedef struct packed {
        logic [3:0] pair_normal_not_loop;
        logic [1:0] deemph_half_bit_sel;
        logic [7:0] rx_buffer_off;
        logic [7:0] tx_buffer_off;
    } rdc_ctrl_t;
endpackage
`default_nettype wire

/* rdc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module rdc_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         arst_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    // ==========================================================
    // Two-stage synchroniser
    logic [W-1:0] stage_one;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage_one <= '0;
            sync_o    <= '0;
        end else begin
            stage_one <= async_i;
            sync_o    <= stage_one;
        end
    end
endmodule
`default_nettype wire

/* rdc_i2c_regs.sv */
// Contract
// - Target only; two-wire bus, standard rate, 7-bit address, direction.
// - Data units are eight bits; first written byte is ignored.
// - Bytes go in ascending order from zero; only whole bytes count.
// - Address bits four, one and zero come from strap inputs.
// - Write keeps loading successive bytes until stop.
// - Twelve byte locations with the documented layout.
// - Byte zero is read-only lane level status, A0 in bit seven.
// - Each status bit follows the live level detector input.
// - Byte one is reserved, read-only, visible on the bus.
// - Byte two bits seven to four select loopback or normal, strapped.
// - Byte two bits three, two select de-emphasis; bits one, zero read-only.
// - Byte three holds per-channel input buffer off bits, reset zero.
// - Byte four holds per-channel output buffer off bits, reset zero.
// - Straps latched at power-on; writes honoured only with mode low.
// - Every received byte acknowledged by pulling data low; an address byte that does not match is left unacknowledged.
// - The clock line is never held low.
`timescale 1ns/1ps
`default_nettype none
module rdc_i2c_regs (
    input  wire logic               ref_clk_i,
    input  wire logic               arst_n_i,
    input  wire logic               scl_i,
    input  wire logic               sda_i,
    input  wire logic               mode_i,
    input  wire rdc_pkg::rdc_strap_t strap_i,
    input  wire logic [7:0]         lane_level_valid_i,
    output logic                    sda_o,
    output logic                    sda_oe_n_o,
    output rdc_pkg::rdc_ctrl_t      ctrl_o
);
    import rdc_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [SYNC_WIDTH-1:0] pins_sync;
    logic                  s_scl, s_sda, s_mode;
    rdc_strap_t            s_strap;
    logic [7:0]            s_level;

    rdc_sync #(
        .W         (SYNC_WIDTH)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .async_i   ({scl_i, sda_i, mode_i, strap_i, lane_level_valid_i}),
        .sync_o    (pins_sync)
    );

    assign {s_scl, s_sda, s_mode, s_strap, s_level} = pins_sync;

    // ==========================================================
    // State
    rdc_state_t state, next_state;
    logic [1:0] strap_cnt, next_strap_cnt;
    logic [2:0] addr_strap, next_addr_strap;
    rdc_ctrl_t  ctrl, next_ctrl;
    logic       scl_q, sda_q;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic       byte_full, next_byte_full;
    logic [7:0] shift_in, next_shift_in;
    logic [7:0] shift_out, next_shift_out;
    logic [3:0] ptr, next_ptr;
    logic       dir_read, next_dir_read;
    logic       dummy_pending, next_dummy_pending;
    logic       nack, next_nack;
    logic       drive_low, next_drive_low;

    // ==========================================================
    // Bus condition detection
    logic scl_rise, scl_fall, start_cond, stop_cond, addr_match;

    assign scl_rise   = s_scl & ~scl_q;
    assign scl_fall   = ~s_scl & scl_q;
    assign start_cond = s_scl & scl_q & sda_q & ~s_sda;
    assign stop_cond  = s_scl & scl_q & ~sda_q & s_sda;

    assign addr_match = (shift_in[7:6] == ADDR_TOP_BITS)
                      & (shift_in[5]   == addr_strap[2])
                      & (shift_in[4:3] == ADDR_MID_BITS)
                      & (shift_in[2]   == addr_strap[1])
                      & (shift_in[1]   == addr_strap[0]);

    // ==========================================================
    // Read data mux
    logic [7:0] rd_byte;

    always_comb begin
        case (ptr)
            OFS_LEVEL_STATUS: rd_byte = s_level;
            OFS_RSVD_ONE:     rd_byte = RSVD_BYTE_VALUE;
            OFS_LOOP_DEEMPH:  rd_byte = {ctrl.pair_normal_not_loop,
                                         ctrl.deemph_half_bit_sel,
                                         RSVD_LBDE_VALUE};
            OFS_RX_DISABLE:   rd_byte = ctrl.rx_buffer_off;
            OFS_TX_DISABLE:   rd_byte = ctrl.tx_buffer_off;
            default:          rd_byte = UNMAPPED_VALUE;
        endcase
    end

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_state         = state;
        next_strap_cnt     = strap_cnt;
        next_addr_strap    = addr_strap;
        next_ctrl          = ctrl;
        next_bit_cnt       = bit_cnt;
        next_byte_full     = byte_full;
        next_shift_in      = shift_in;
        next_shift_out     = shift_out;
        next_ptr           = ptr;
        next_dir_read      = dir_read;
        next_dummy_pending = dummy_pending;
        next_nack          = nack;
        next_drive_low     = drive_low;

        // Strap capture once synchronisers have settled
        if (strap_cnt != STRAP_SETTLE) begin
            next_strap_cnt = strap_cnt + 2'h1;
            if (strap_cnt == STRAP_SETTLE - 2'h1) begin
                next_ctrl.pair_normal_not_loop =
                    {4{s_strap.loop_strap_n}};
                next_ctrl.deemph_half_bit_sel =
                    {s_strap.deemph_strap_grp_a,
                     s_strap.deemph_strap_grp_b};
                next_addr_strap = {s_strap.addr_strap_bit_four,
                                   s_strap.addr_strap_bit_one,
                                   s_strap.addr_strap_bit_zero};
            end
        end

        if (start_cond) begin
            next_state     = ST_ADDR;
            next_bit_cnt   = 3'h0;
            next_byte_full = 1'b0;
            next_ptr       = OFS_LEVEL_STATUS;
            next_drive_low = 1'b0;
        end else if (stop_cond) begin
            next_state     = ST_IDLE;
            next_drive_low = 1'b0;
        end else begin
            case (state)
                ST_IDLE: next_drive_low = 1'b0;
                ST_ADDR, ST_WDATA: begin
                    if (scl_rise) begin
                        next_shift_in  = {shift_in[6:0], s_sda};
                        next_bit_cnt   = bit_cnt + 3'h1;
                        next_byte_full = (bit_cnt == 3'h7);
                    end else if (scl_fall && byte_full) begin
                        next_byte_full = 1'b0;
                        if (state == ST_ADDR) begin
                            if (addr_match) begin
                                next_state     = ST_ACK_ADDR;
                                next_dir_read  = shift_in[0];
                                next_drive_low = 1'b1;
                            end else begin
                                next_state = ST_IDLE;
                            end
                        end else begin
                            next_state     = ST_ACK_W;
                            next_drive_low = 1'b1;
                            if (dummy_pending) begin
                                next_dummy_pending = 1'b0;
                            end else begin
                                if (!s_mode) begin
                                    case (ptr)
                                        OFS_LOOP_DEEMPH: begin
                                            next_ctrl.pair_normal_not_loop =
                                                shift_in[LOOP_FIELD_HI:
                                                         LOOP_FIELD_LO];
                                            next_ctrl.deemph_half_bit_sel =
                                                shift_in[DEEMPH_FIELD_HI:
                                                         DEEMPH_FIELD_LO];
                                        end
                                        OFS_RX_DISABLE: begin
                                            next_ctrl.rx_buffer_off =
                                                shift_in;
                                        end
                                        OFS_TX_DISABLE: begin
                                            next_ctrl.tx_buffer_off =
                                                shift_in;
                                        end
                                        default: next_ctrl = ctrl;
                                    endcase
                                end
                                if (ptr != OFS_SATURATE) begin
                                    next_ptr = ptr + 4'h1;
                                end
                            end
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (dir_read == DIR_READ) begin
                            next_state     = ST_RDATA;
                            next_shift_out = rd_byte;
                            next_drive_low = ~rd_byte[7];
                        end else begin
                            next_state         = ST_WDATA;
                            next_dummy_pending = 1'b1;
                            next_drive_low     = 1'b0;
                        end
                    end
                end
                ST_ACK_W: begin
                    if (scl_fall) begin
                        next_state     = ST_WDATA;
                        next_drive_low = 1'b0;
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        next_bit_cnt   = bit_cnt + 3'h1;
                        next_byte_full = (bit_cnt == 3'h7);
                    end else if (scl_fall) begin
                        if (byte_full) begin
                            next_byte_full = 1'b0;
                            next_state     = ST_ACK_R;
                            next_drive_low = 1'b0;
                            if (ptr != OFS_SATURATE) begin
                                next_ptr = ptr + 4'h1;
                            end
                        end else begin
                            next_shift_out = {shift_out[6:0], 1'b0};
                            next_drive_low = ~shift_out[6];
                        end
                    end
                end
                ST_ACK_R: begin
                    if (scl_rise) begin
                        next_nack = s_sda;
                    end else if (scl_fall) begin
                        if (nack) begin
                            next_state = ST_IDLE;
                        end else begin
                            next_state     = ST_RDATA;
                            next_shift_out = rd_byte;
                            next_drive_low = ~rd_byte[7];
                        end
                    end
                end
                default: begin
                    next_state     = ST_IDLE;
                    next_drive_low = 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state         <= ST_IDLE;
            strap_cnt     <= 2'h0;
            addr_strap    <= 3'h0;
            ctrl          <= {4'h0, 2'h0, RX_OFF_RESET, TX_OFF_RESET};
            scl_q         <= 1'b1;
            sda_q         <= 1'b1;
            bit_cnt       <= 3'h0;
            byte_full     <= 1'b0;
            shift_in      <= 8'h00;
            shift_out     <= 8'h00;
            ptr           <= 4'h0;
            dir_read      <= 1'b0;
            dummy_pending <= 1'b0;
            nack          <= 1'b0;
            drive_low     <= 1'b0;
        end else begin
            state         <= next_state;
            strap_cnt     <= next_strap_cnt;
            addr_strap    <= next_addr_strap;
            ctrl          <= next_ctrl;
            scl_q         <= s_scl;
            sda_q         <= s_sda;
            bit_cnt       <= next_bit_cnt;
            byte_full     <= next_byte_full;
            shift_in      <= next_shift_in;
            shift_out     <= next_shift_out;
            ptr           <= next_ptr;
            dir_read      <= next_dir_read;
            dummy_pending <= next_dummy_pending;
            nack          <= next_nack;
            drive_low     <= next_drive_low;
        end
    end

    // ==========================================================
    // Outputs; the clock line has no driver at all
    assign sda_o      = 1'b0;
    assign sda_oe_n_o = ~drive_low;
    assign ctrl_o     = ctrl;
endmodule
`default_nettype wire

/* rdc_i2c_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module rdc_regs_chk (
    input  wire logic                ref_clk_i,
    input  wire logic                arst_n_i,
    input  wire logic                scl_i,
    input  wire logic                sda_i,
    input  wire logic                mode_i,
    input  wire rdc_pkg::rdc_strap_t strap_i,
    input  wire logic [7:0]          lane_level_valid_i,
    input  wire logic                sda_o,
    input  wire logic                sda_oe_n_o,
    input  wire rdc_pkg::rdc_ctrl_t  ctrl_o
);
    import rdc_pkg::*;
    // ==========================================================
    // Cycles the mode input has stood high
    logic [2:0] mode_cnt;
    logic [2:0] next_mode_cnt;
    always_comb begin
        next_mode_cnt = mode_cnt;
        if (!mode_i) begin
            next_mode_cnt = 3'h0;
        end else if (mode_cnt != 3'h7) begin
            next_mode_cnt = mode_cnt + 3'h1;
        end
    end
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_cnt <= 3'h0;
        end else begin
            mode_cnt <= next_mode_cnt;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_rel;
        $rose(arst_n_i);
    endsequence
    sequence s_ack_start;
        $fell(sda_oe_n_o);
    endsequence
    property p_rst_val;
        s_rel |-> (ctrl_o.rx_buffer_off == RX_OFF_RESET)
            && (ctrl_o.tx_buffer_off == TX_OFF_RESET) && sda_oe_n_o;
    endproperty
    property p_strap_load;
        s_rel |-> ##4 (
            (ctrl_o.pair_normal_not_loop == {4{strap_i.loop_strap_n}})
            && (ctrl_o.deemph_half_bit_sel ==
                {strap_i.deemph_strap_grp_a, strap_i.deemph_strap_grp_b}));
    endproperty
    property p_open_drain;
        sda_o == 1'b0;
    endproperty
    property p_drive_in_low;
        $changed(sda_oe_n_o) |-> !scl_i;
    endproperty
    property p_hold_high;
        (!sda_oe_n_o && scl_i) |=> (!sda_oe_n_o || !scl_i);
    endproperty
    property p_mode_gate;
        (mode_cnt == 3'h7 && mode_i) |-> $stable(ctrl_o);
    endproperty
    property p_rx_commit;
        $changed(ctrl_o.rx_buffer_off) |-> s_ack_start;
    endproperty
    property p_tx_commit;
        $changed(ctrl_o.tx_buffer_off) |-> s_ack_start;
    endproperty
    a_rst_val: assert property (p_rst_val)
        else $error("buffer disable bytes not cleared at reset");
    a_strap_load: assert property (p_strap_load)
        else $error("strap values not loaded");
    a_open_drain: assert property (p_open_drain)
        else $error("data pin value not low");
    a_drive_in_low: assert property (p_drive_in_low)
        else $error("data drive changed while bus clock high");
    a_hold_high: assert property (p_hold_high)
        else $error("data released during clock high");
    a_mode_gate: assert property (p_mode_gate)
        else $error("control changed while writes locked");
    a_rx_commit: assert property (p_rx_commit)
        else $error("input disable changed outside a byte end");
    a_tx_commit: assert property (p_tx_commit)
        else $error("output disable changed outside a byte end");
endmodule
bind rdc_i2c_regs rdc_regs_chk i_rdc_regs_chk (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .scl_i(scl_i),
    .sda_i(sda_i), .mode_i(mode_i), .strap_i(strap_i),
    .lane_level_valid_i(lane_level_valid_i), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .ctrl_o(ctrl_o)
);
`default_nettype wire

/* rdc_bus_master.sv */
`timescale 1ns/1ps
`default_nettype none
module rdc_bus_master (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // One bus clock: low six cycles, high two
    task automatic clk_bit(input logic d, output logic r);
        tick(2);
        sda_o = d;
        tick(4);
        scl_o = 1'b1;
        tick(2);
        r = sda_i;
        scl_o = 1'b0;
    endtask
    task automatic start();
        tick(2);
        sda_o = 1'b1;
        tick(4);
        scl_o = 1'b1;
        tick(4);
        sda_o = 1'b0;
        tick(4);
        scl_o = 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sda_o = 1'b0;
        tick(4);
        scl_o = 1'b1;
        tick(4);
        sda_o = 1'b1;
        tick(4);
    endtask
    // Most significant bit first; a short count leaves the byte partial
    task automatic send_bits(input logic [7:0] b, input int n,
                             output logic ack);
        logic r;
        ack = 1'b0;
        for (int i = 0; i < n; i++) clk_bit(b[7-i], r);
        if (n == 8) begin
            clk_bit(1'b1, r);
            ack = ~r;
        end
    endtask
    task automatic recv_byte(input logic more, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
        clk_bit(~more, r);
    endtask
endmodule
`default_nettype wire

/* rdc_i2c_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rdc_i2c_regs_tb_top;
    import rdc_pkg::*;
    logic       clk = 1'b0;
    logic       arst_n;
    logic       mode;
    rdc_strap_t strap;
    logic [7:0] lvl;
    logic       scl;
    logic       m_sda;
    logic       dev_sda;
    logic       oe_n;
    rdc_ctrl_t  ctrl;
    logic [6:0] dev;
    logic [7:0] rdq[$];
    logic       a;
    int         error_cnt = 0;
    int         n_checks = 0;
    wire        sda = m_sda & (oe_n | dev_sda);
    always #12.5 clk = ~clk;
    assign dev = {ADDR_TOP_BITS, strap.addr_strap_bit_four, ADDR_MID_BITS,
                  strap.addr_strap_bit_one, strap.addr_strap_bit_zero};
    rdc_i2c_regs i_rdc_i2c_regs (
        .ref_clk_i(clk), .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda),
        .mode_i(mode), .strap_i(strap), .lane_level_valid_i(lvl),
        .sda_o(dev_sda), .sda_oe_n_o(oe_n), .ctrl_o(ctrl)
    );
    rdc_bus_master i_rdc_bus_master (
        .clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(m_sda)
    );
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Write: address, dummy byte, then bytes from position zero
    task automatic wr(input logic [5:0][7:0] q, input int n,
                      input logic stp);
        i_rdc_bus_master.start();
        i_rdc_bus_master.send_bits({dev, 1'b0}, 8, a);
        chk({7'h0, a}, 8'h01);
        for (int i = 0; i < n; i++) begin
            i_rdc_bus_master.send_bits(q[5-i], 8, a);
            chk({7'h0, a}, 8'h01);
        end
        if (stp) i_rdc_bus_master.stop();
    endtask
    task automatic rd(input int n);
        logic [7:0] b;
        rdq.delete();
        i_rdc_bus_master.start();
        i_rdc_bus_master.send_bits({dev, 1'b1}, 8, a);
        chk({7'h0, a}, 8'h01);
        for (int i = 0; i < n; i++) begin
            i_rdc_bus_master.recv_byte(i < n - 1, b);
            rdq.push_back(b);
        end
        i_rdc_bus_master.stop();
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        $display("wrong value at %0t: run did not finish", $time);
        end_sim();
    end
    initial begin
        arst_n = 1'b0;
        mode = 1'b0;
        strap = rdc_strap_t'(6'h15);
        lvl = 8'hA5;
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        repeat (40) @(negedge clk);
        // Power-on values and full map read
        chk({4'h0, ctrl.pair_normal_not_loop}, 8'h00);
        chk({6'h0, ctrl.deemph_half_bit_sel}, 8'h02);
        chk(ctrl.rx_buffer_off, 8'h00);
        chk(ctrl.tx_buffer_off, 8'h00);
        rd(12);
        chk(rdq[0], 8'hA5);
        chk(rdq[1], 8'h00);
        chk(rdq[2], 8'h08);
        for (int i = 3; i < 12; i++) chk(rdq[i], 8'h00);
        $display("test reset values done");
        // Foreign addresses get no acknowledge
        for (int i = 0; i < 4; i++) begin
            i_rdc_bus_master.start();
            i_rdc_bus_master.send_bits({dev ^ (7'h10 >> (i + (i > 0))), 1'b0},
                                       8, a);
            chk({7'h0, a}, 8'h00);
            i_rdc_bus_master.stop();
        end
        $display("test address done");
        // Burst write, read-only positions, repeated start read
        lvl = 8'h3C;
        wr({8'h77, 8'h11, 8'h22, 8'hF7, 8'h5A, 8'hC3}, 6, 1'b0);
        chk(ctrl.rx_buffer_off, 8'h5A);
        chk(ctrl.tx_buffer_off, 8'hC3);
        rd(5);
        chk(rdq[0], 8'h3C);
        chk(rdq[1], 8'h00);
        chk(rdq[2], 8'hF4);
        chk(rdq[3], 8'h5A);
        chk(rdq[4], 8'hC3);
        $display("test burst done");
        // Stop in mid byte keeps the earlier bytes only
        wr({8'h00, 8'h00, 8'h00, 8'hF4, 8'h00, 8'h00}, 4, 1'b0);
        i_rdc_bus_master.send_bits(8'h00, 4, a);
        i_rdc_bus_master.stop();
        chk(ctrl.rx_buffer_off, 8'h5A);
        $display("test partial byte done");
        // Writes locked, then loopback with input disables
        mode = 1'b1;
        repeat (10) @(negedge clk);
        wr({8'h00, 8'h00, 8'h00, 8'h0C, 8'h00, 8'h00}, 6, 1'b1);
        chk(ctrl.rx_buffer_off, 8'h5A);
        chk(ctrl.tx_buffer_off, 8'hC3);
        chk({4'h0, ctrl.pair_normal_not_loop}, 8'h0F);
        chk({6'h0, ctrl.deemph_half_bit_sel}, 8'h01);
        mode = 1'b0;
        repeat (10) @(negedge clk);
        wr({8'h00, 8'h00, 8'h00, 8'h0C, 8'h55, 8'h00}, 6, 1'b1);
        chk({4'h0, ctrl.pair_normal_not_loop}, 8'h00);
        chk({6'h0, ctrl.deemph_half_bit_sel}, 8'h03);
        chk(ctrl.rx_buffer_off, 8'h55);
        chk(ctrl.tx_buffer_off, 8'h00);
        $display("test write lock done");
        end_sim();
    end
endmodule
`default_nettype wire
